/* File: verilog/psp_sync.sv */
`timescale 1ns/10ps

package psp_pkg;
    // Chip select patterns (bit 1 = CS1-, bit 0 = CS0-, active low)
    localparam logic [1:0] PSP_CS_CMD = 2'h2;
    localparam logic [1:0] PSP_CS_CTL = 2'h1;
    // Data port offset in the command block
    localparam logic [2:0] PSP_DATA_ADDR = 3'h0;
    // Link-side pin bundle layout
    localparam int PSP_PIN_W = 24;
    localparam int PSP_PIN_CS = 22;
    localparam int PSP_PIN_DA = 19;
    localparam int PSP_PIN_DIOR = 18;
    localparam int PSP_PIN_DIOW = 17;
    localparam int PSP_PIN_DMACK = 16;
    // Idle levels of the pin bundle: selects, strobes, acknowledge negated
    localparam logic [23:0] PSP_PIN_IDLE = 24'hC70000;
    // Core-to-link bundle and link-to-core bundle widths
    localparam int PSP_C2L_W = 6;
    localparam int PSP_L2C_W = 6;
    // Idle levels of the two pins sampled in the core domain
    localparam logic [5:0] PSP_L2C_IDLE = 6'h30;
    // DMA request handshake states
    typedef enum logic [1:0] {DQ_IDLE, DQ_REQ, DQ_BURST, DQ_DRAIN} psp_dq_t;
endpackage

// Two-stage synchroniser; only the second stage is visible outside
module psp_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    // Destination clock and reset
    input wire logic clk,
    input wire logic rst,
    // Asynchronous input and synchronised output
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    // Metastable stage feeds the output stage only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_r <= INIT;
            q <= INIT;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule

/* File: verilog/psp_port.sv */
`timescale 1ns/10ps

// Behaviour
// - Chip selects choose between command block and control block registers.
// - Three-bit address together with chip selects picks register or data port.
// - During reset protocol the second device asserts the presence/active pin.
// - Otherwise the selected device may assert the active pin when busy.
// - Byte-wide register transfers use only the low data lanes.
// - Data port transfers are 16 bits unless byte data mode is configured.
// - Reads use the read strobe; transfer completes on its negation.
// - Writes use the write strobe; device takes data on its negation.
// - In data-out bursts device captures data on both host strobe edges.
// - Stop asserted during a burst terminates it; device recognises the end.
// - Device drives ready, data-in strobe, I/O ready, DMA request, interrupt.
// - DMA request held until acknowledge seen, reasserted while more data remains.
// - Device toggles data-in strobe per word; host latches both edges; halting pauses.
// - Device asserts its ready in data-out bursts and negates it to pause.
// - Interrupt line driven only when selected and interrupts enabled, else released.
module psp_port #(
    parameter bit DATA8 = 1'b0
) (
    // Core clock and reset
    input wire logic clock,
    input wire logic rst,
    // Link sampling clock
    input wire logic link_clk,
    // Host-driven pins
    input wire logic [1:0] cs_n,
    input wire logic [2:0] da,
    input wire logic dior_n,
    input wire logic diow_n,
    input wire logic dmack_n,
    // Data bus pin
    input wire logic [15:0] dd_in,
    output logic [15:0] dd_out,
    output logic dd_oe_n,
    // Device-driven pins
    output logic iordy_out,
    output logic iordy_oe_n,
    output logic dmarq_out,
    output logic dmarq_oe_n,
    output logic intrq_out,
    output logic intrq_oe_n,
    output logic dasp_out,
    output logic dasp_oe_n,
    // Device state from core logic
    input wire logic dev_sel,
    input wire logic int_pending,
    input wire logic int_disable,
    input wire logic is_dev1,
    input wire logic reset_proto,
    input wire logic dev_active,
    // Register write
    output logic reg_wr_valid,
    output logic reg_wr_ctl,
    output logic [2:0] reg_wr_addr,
    output logic [15:0] reg_wr_data,
    // Register read
    output logic reg_rd_req,
    output logic reg_rd_ctl,
    output logic [2:0] reg_rd_addr,
    input wire logic [15:0] reg_rd_data,
    // DMA control
    input wire logic dma_pending,
    input wire logic dma_dir_in,
    output logic burst_end,
    // Data-in words toward host
    input wire logic in_valid,
    input wire logic [15:0] in_data,
    output logic in_ready,
    // Data-out words from host
    output logic out_valid,
    output logic [15:0] out_data,
    input wire logic out_ready
);
    import psp_pkg::*;

    logic l_rst_meta_r, l_rst;
    logic [PSP_PIN_W-1:0] l_pin;
    logic [PSP_C2L_W-1:0] l_c2l;
    logic [PSP_L2C_W-1:0] c_l2c;
    logic l_dior_q_r, l_diow_q_r;
    logic l_rd_busy_r, l_rd_drive_r, l_rd_t_r, l_rd_seen_r, l_rd_ctl_r;
    logic [2:0] l_rd_addr_r;
    logic l_wr_t_r, l_wr_ctl_r;
    logic [2:0] l_wr_addr_r;
    logic [15:0] l_wr_data_r, l_dd_r, l_out_word_r, c_rd_data_r, c_in_word_r;
    logic l_started_r, l_out_t_r, l_out_pend_r, l_out_seen_r;
    logic l_in_seen_r, l_in_phase_r, l_dstb_r, l_in_ack_t_r;
    logic c_rd_ack_t_r, c_rd_seen_r, c_wr_seen_r, c_out_seen_r, c_out_ack_t_r;
    logic c_in_busy_r, c_in_req_t_r, c_in_seen_r, c_started_r;
    psp_dq_t dq_r, dq_nxt;

    // Link reset: asserts at once, releases on the link clock
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            l_rst_meta_r <= 1'b1;
            l_rst <= 1'b1;
        end else begin
            l_rst_meta_r <= 1'b0;
            l_rst <= l_rst_meta_r;
        end
    end

    // Pins into the link domain
    psp_sync #(.W(PSP_PIN_W), .INIT(PSP_PIN_IDLE)) u_pin_sync (
        .clk(link_clk),
        .rst(l_rst),
        .d({cs_n, da, dior_n, diow_n, dmack_n, dd_in}),
        .q(l_pin)
    );

    // Core handshakes and levels into the link domain
    psp_sync #(.W(PSP_C2L_W)) u_c2l_sync (
        .clk(link_clk),
        .rst(l_rst),
        .d({c_rd_ack_t_r, c_out_ack_t_r, c_in_req_t_r, dev_sel, dma_dir_in, out_ready}),
        .q(l_c2l)
    );

    // Link toggles and the two burst pins into the core domain
    psp_sync #(.W(PSP_L2C_W), .INIT(PSP_L2C_IDLE)) u_l2c_sync (
        .clk(clock),
        .rst(rst),
        .d({dmack_n, diow_n, l_rd_t_r, l_wr_t_r, l_out_t_r, l_in_ack_t_r}),
        .q(c_l2c)
    );

    // Link-side decode of the synchronised pins
    wire [1:0] l_cs = l_pin[PSP_PIN_CS+:2];
    wire [2:0] l_da = l_pin[PSP_PIN_DA+:3];
    wire l_dior = l_pin[PSP_PIN_DIOR];
    wire l_diow = l_pin[PSP_PIN_DIOW];
    wire l_burst = !l_pin[PSP_PIN_DMACK] && l_c2l[2];
    wire [15:0] l_dd = l_pin[15:0];
    wire l_sel_cmd = l_cs == PSP_CS_CMD;
    wire l_sel_ctl = l_cs == PSP_CS_CTL;
    // Register cycles only outside acknowledge; host keeps selects off then
    wire l_pio = (l_sel_cmd || l_sel_ctl) && l_pin[PSP_PIN_DMACK] && l_c2l[2];
    wire l_dport = l_sel_cmd && l_da == PSP_DATA_ADDR;
    wire l_wide = l_dport && !DATA8;
    wire l_dior_fall = l_dior_q_r && !l_dior;
    wire l_dior_rise = !l_dior_q_r && l_dior;
    wire l_diow_rise = !l_diow_q_r && l_diow;
    wire l_stop = l_burst && l_diow;
    wire l_burst_in = l_burst && l_c2l[1];
    wire l_burst_out = l_burst && !l_c2l[1];
    wire l_rd_ack = l_c2l[5] != l_rd_seen_r;
    wire l_out_ack = l_c2l[4] != l_out_seen_r;
    wire l_flow = l_started_r && !l_stop;
    // A pause in host strobes simply yields no edge; nothing times the burst out
    wire l_hs_edge = l_burst_out && l_flow && (l_dior != l_dior_q_r);
    wire l_in_go = l_burst_in && l_flow && !l_dior && !l_in_phase_r
        && (l_c2l[3] != l_in_seen_r);

    // Strobe history for edge detection
    always_ff @(posedge link_clk or posedge l_rst) begin
        if (l_rst) begin
            l_dior_q_r <= 1'b1;
            l_diow_q_r <= 1'b1;
        end else begin
            l_dior_q_r <= l_dior;
            l_diow_q_r <= l_diow;
        end
    end

    // Register read: request on strobe assertion, hold I/O ready low until data arrives
    always_ff @(posedge link_clk or posedge l_rst) begin
        if (l_rst) begin
            l_rd_busy_r <= 1'b0;
            l_rd_drive_r <= 1'b0;
            l_rd_t_r <= 1'b0;
            l_rd_seen_r <= 1'b0;
            l_rd_ctl_r <= 1'b0;
            l_rd_addr_r <= 3'h0;
        end else begin
            if (l_dior_fall && l_pio && !l_rd_busy_r) begin
                l_rd_busy_r <= 1'b1;
                l_rd_t_r <= ~l_rd_t_r;
                l_rd_ctl_r <= l_sel_ctl;
                l_rd_addr_r <= l_da;
            end else if (l_rd_ack) begin
                l_rd_busy_r <= 1'b0;
                l_rd_seen_r <= l_c2l[5];
            end
            // Bus released once the host negates the strobe
            if (l_dior_rise || !l_pio) begin
                l_rd_drive_r <= 1'b0;
            end else if (l_rd_ack && !l_dior) begin
                l_rd_drive_r <= 1'b1;
            end
        end
    end

    // Register write: take the bus on the negating edge of the write strobe
    always_ff @(posedge link_clk or posedge l_rst) begin
        if (l_rst) begin
            l_wr_t_r <= 1'b0;
            l_wr_ctl_r <= 1'b0;
            l_wr_addr_r <= 3'h0;
            l_wr_data_r <= 16'h0000;
        end else if (l_diow_rise && l_pio) begin
            l_wr_t_r <= ~l_wr_t_r;
            l_wr_ctl_r <= l_sel_ctl;
            l_wr_addr_r <= l_da;
            l_wr_data_r <= l_wide ? l_dd : {8'h00, l_dd[7:0]};
        end
    end

    // Burst flow starts once stop is seen negated
    always_ff @(posedge link_clk or posedge l_rst) begin
        if (l_rst) begin
            l_started_r <= 1'b0;
        end else if (!l_burst) begin
            l_started_r <= 1'b0;
        end else if (!l_diow) begin
            l_started_r <= 1'b1;
        end
    end

    // Data-out capture on either strobe edge; one word in flight to the core
    always_ff @(posedge link_clk or posedge l_rst) begin
        if (l_rst) begin
            l_out_t_r <= 1'b0;
            l_out_pend_r <= 1'b0;
            l_out_seen_r <= 1'b0;
            l_out_word_r <= 16'h0000;
        end else if (l_hs_edge && !l_out_pend_r) begin
            l_out_word_r <= l_dd;
            l_out_t_r <= ~l_out_t_r;
            l_out_pend_r <= 1'b1;
        end else if (l_out_ack) begin
            l_out_pend_r <= 1'b0;
            l_out_seen_r <= l_c2l[4];
        end
    end

    // Data-in: place the word, then toggle the strobe one link cycle later for setup
    always_ff @(posedge link_clk or posedge l_rst) begin
        if (l_rst) begin
            l_in_seen_r <= 1'b0;
            l_in_phase_r <= 1'b0;
            l_dstb_r <= 1'b1;
            l_in_ack_t_r <= 1'b0;
        end else if (l_in_phase_r) begin
            l_in_phase_r <= 1'b0;
            l_dstb_r <= ~l_dstb_r;
            l_in_ack_t_r <= ~l_in_ack_t_r;
        end else if (l_in_go) begin
            l_in_seen_r <= l_c2l[3];
            l_in_phase_r <= 1'b1;
        end else if (!l_burst) begin
            l_dstb_r <= 1'b1;
        end
    end

    // Data bus word: read data or data-in word; core words are stable under handshake
    always_ff @(posedge link_clk or posedge l_rst) begin
        if (l_rst) begin
            l_dd_r <= 16'h0000;
        end else if (l_in_go) begin
            l_dd_r <= c_in_word_r;
        end else if (l_rd_ack) begin
            l_dd_r <= l_wide ? c_rd_data_r : {8'h00, c_rd_data_r[7:0]};
        end
    end

    // I/O ready, device ready or data-in strobe, by mode; released when not selected
    always_ff @(posedge link_clk or posedge l_rst) begin
        if (l_rst) begin
            iordy_out <= 1'b1;
            iordy_oe_n <= 1'b1;
        end else begin
            iordy_oe_n <= !l_c2l[2];
            if (l_burst_in) begin
                iordy_out <= l_dstb_r;
            end else if (l_burst_out) begin
                iordy_out <= !(l_c2l[0] && !l_out_pend_r && !l_hs_edge && !l_stop);
            end else begin
                iordy_out <= !(l_rd_busy_r || (l_dior_fall && l_pio));
            end
        end
    end

    assign dd_out = l_dd_r;
    assign dd_oe_n = !(l_rd_drive_r || l_burst_in);

    // Core-side view of the handshakes and burst pins
    wire c_dmack = !c_l2c[5];
    wire c_stop = c_dmack && c_l2c[4];
    wire c_rd_chg = c_l2c[3] != c_rd_seen_r;
    wire c_wr_chg = c_l2c[2] != c_wr_seen_r;
    wire c_out_chg = c_l2c[1] != c_out_seen_r;
    wire c_in_done = c_l2c[0] != c_in_seen_r;

    // Read requests to core and answer back; data sampled while the request stands
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            c_rd_seen_r <= 1'b0;
            c_rd_ack_t_r <= 1'b0;
            c_rd_data_r <= 16'h0000;
            reg_rd_req <= 1'b0;
            reg_rd_ctl <= 1'b0;
            reg_rd_addr <= 3'h0;
        end else begin
            reg_rd_req <= c_rd_chg && !reg_rd_req;
            if (c_rd_chg && !reg_rd_req) begin
                c_rd_seen_r <= c_l2c[3];
                reg_rd_ctl <= l_rd_ctl_r;
                reg_rd_addr <= l_rd_addr_r;
            end
            if (reg_rd_req) begin
                c_rd_data_r <= reg_rd_data;
                c_rd_ack_t_r <= ~c_rd_ack_t_r;
            end
        end
    end

    // Register writes to core
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            c_wr_seen_r <= 1'b0;
            reg_wr_valid <= 1'b0;
            reg_wr_ctl <= 1'b0;
            reg_wr_addr <= 3'h0;
            reg_wr_data <= 16'h0000;
        end else begin
            reg_wr_valid <= c_wr_chg;
            if (c_wr_chg) begin
                c_wr_seen_r <= c_l2c[2];
                reg_wr_ctl <= l_wr_ctl_r;
                reg_wr_addr <= l_wr_addr_r;
                reg_wr_data <= l_wr_data_r;
            end
        end
    end

    // Data-out words to core, acknowledged at once
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            c_out_seen_r <= 1'b0;
            c_out_ack_t_r <= 1'b0;
            out_valid <= 1'b0;
            out_data <= 16'h0000;
        end else begin
            out_valid <= c_out_chg;
            if (c_out_chg) begin
                c_out_seen_r <= c_l2c[1];
                c_out_ack_t_r <= ~c_out_ack_t_r;
                out_data <= l_out_word_r;
            end
        end
    end

    // Data-in holding word; one word deep, so in_ready stalls the source
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            c_in_busy_r <= 1'b0;
            c_in_req_t_r <= 1'b0;
            c_in_seen_r <= 1'b0;
            c_in_word_r <= 16'h0000;
        end else if (in_valid && !c_in_busy_r) begin
            c_in_busy_r <= 1'b1;
            c_in_req_t_r <= ~c_in_req_t_r;
            c_in_word_r <= in_data;
        end else if (c_in_done) begin
            c_in_busy_r <= 1'b0;
            c_in_seen_r <= c_l2c[0];
        end
    end

    assign in_ready = !c_in_busy_r;

    // DMA request handshake
    always_comb begin
        dq_nxt = dq_r;
        unique case (dq_r)
            DQ_IDLE: if (dma_pending && dev_sel && !c_dmack) dq_nxt = DQ_REQ;
            DQ_REQ: if (c_dmack) dq_nxt = DQ_BURST;
            DQ_BURST: begin
                if (!c_dmack) begin
                    dq_nxt = DQ_IDLE;
                end else if (c_started_r && c_stop) begin
                    dq_nxt = DQ_DRAIN;
                end
            end
            DQ_DRAIN: if (!c_dmack) dq_nxt = DQ_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            dq_r <= DQ_IDLE;
            c_started_r <= 1'b0;
            burst_end <= 1'b0;
        end else begin
            dq_r <= dq_nxt;
            c_started_r <= (dq_r == DQ_BURST) && (c_started_r || !c_stop);
            burst_end <= (dq_r == DQ_BURST) && (dq_nxt == DQ_DRAIN);
        end
    end

    assign dmarq_out = (dq_r == DQ_REQ) || (dq_r == DQ_BURST);
    assign dmarq_oe_n = !dev_sel;

    // Interrupt and active pins, registered to stay glitch free
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            intrq_out <= 1'b0;
            intrq_oe_n <= 1'b1;
            dasp_out <= 1'b1;
            dasp_oe_n <= 1'b1;
        end else begin
            intrq_out <= int_pending;
            intrq_oe_n <= !(dev_sel && !int_disable);
            dasp_out <= 1'b0;
            dasp_oe_n <= !(reset_proto ? is_dev1 : (dev_sel && dev_active));
        end
    end

    property p_intrq_release;
        @(posedge clock) disable iff (rst) (!dev_sel || int_disable) |=> intrq_oe_n;
    endproperty
    a_intrq_release: assert property (p_intrq_release) else $error("intrq not released");

    property p_dasp_dev1;
        @(posedge clock) disable iff (rst) (reset_proto && is_dev1) |=> (!dasp_oe_n && !dasp_out);
    endproperty
    a_dasp_dev1: assert property (p_dasp_dev1) else $error("presence not shown");

    property p_dmarq_hold;
        @(posedge clock) disable iff (rst) (dq_r == DQ_REQ && !c_dmack) |=> dmarq_out;
    endproperty
    a_dmarq_hold: assert property (p_dmarq_hold) else $error("request dropped early");

    property p_stop_ends;
        @(posedge clock) disable iff (rst)
            (dq_r == DQ_BURST && c_started_r && c_stop && c_dmack) |=> (!dmarq_out ##0 burst_end);
    endproperty
    a_stop_ends: assert property (p_stop_ends) else $error("stop did not end burst");

    property p_wr_take;
        @(posedge link_clk) disable iff (l_rst) (l_diow_rise && l_pio)
            |=> (l_wr_t_r != $past(l_wr_t_r) && l_wr_ctl_r == $past(l_sel_ctl)
            && l_wr_addr_r == $past(l_da) && l_wr_data_r[7:0] == $past(l_dd[7:0]));
    endproperty
    a_wr_take: assert property (p_wr_take) else $error("write not taken");

    property p_low_lanes;
        @(posedge link_clk) disable iff (l_rst)
            (l_diow_rise && l_pio && !l_wide) |=> l_wr_data_r[15:8] == 8'h00;
    endproperty
    a_low_lanes: assert property (p_low_lanes) else $error("upper lanes used");

    property p_rd_release;
        @(posedge link_clk) disable iff (l_rst) (l_dior_rise && !l_burst_in) |=> dd_oe_n;
    endproperty
    a_rd_release: assert property (p_rd_release) else $error("bus held after read");

    property p_out_capture;
        @(posedge link_clk) disable iff (l_rst) (l_hs_edge && !l_out_pend_r)
            |=> (l_out_pend_r && l_out_word_r == $past(l_dd));
    endproperty
    a_out_capture: assert property (p_out_capture) else $error("strobe edge lost");

    property p_ready_pause;
        @(posedge link_clk) disable iff (l_rst) (l_burst_out && l_out_pend_r) |=> iordy_out;
    endproperty
    a_ready_pause: assert property (p_ready_pause) else $error("ready while word pending");

    property p_dstb_setup;
        @(posedge link_clk) disable iff (l_rst) l_in_go |=> (l_dstb_r == $past(l_dstb_r)) ##1
            (l_dstb_r != $past(l_dstb_r, 2));
    endproperty
    a_dstb_setup: assert property (p_dstb_setup) else $error("strobe timing wrong");
endmodule

/* File: sim/psp_host.sv */
`timescale 1ns/10ps

// Host side of the port: selects, address, strobes and data lanes
module psp_host (
    // Paces the pins; the real host is asynchronous
    input wire logic clock,
    // Device side of the shared pins
    input wire logic [15:0] dd_out,
    input wire logic dd_oe_n,
    input wire logic iordy_out,
    // Host-driven pins
    output logic [1:0] cs_n,
    output logic [2:0] da,
    output logic dior_n,
    output logic diow_n,
    output logic dmack_n,
    output logic [15:0] dd_in
);
    logic [15:0] dd_h = 16'h0000;
    logic drv = 1'b0;
    // Released lanes show the inverse, so stale data never matches
    assign dd_in = !dd_oe_n ? dd_out : (drv ? dd_h : ~dd_h);
    // Idle host: nothing selected, strobes and acknowledge negated
    initial begin
        cs_n = 2'h3;
        da = 3'h0;
        dior_n = 1'b1;
        diow_n = 1'b1;
        dmack_n = 1'b1;
    end
    // Write cycle; spaced well apart so the link copy stays stable
    task automatic wr(input logic [1:0] cs, input logic [2:0] a, input logic [15:0] d);
        @(negedge clock);
        cs_n = cs;
        da = a;
        dd_h = d;
        drv = 1'b1;
        repeat (2) @(negedge clock);
        diow_n = 1'b0;
        repeat (3) @(negedge clock);
        diow_n = 1'b1;
        repeat (3) @(negedge clock);
        cs_n = 2'h3;
        drv = 1'b0;
        repeat (4) @(negedge clock);
    endtask
    // Read cycle; the strobe is held until the device says ready
    task automatic rd(input logic [1:0] cs, input logic [2:0] a, output logic [15:0] d);
        int n;
        @(negedge clock);
        cs_n = cs;
        da = a;
        repeat (2) @(negedge clock);
        dior_n = 1'b0;
        repeat (4) @(negedge clock);
        n = 0;
        while (iordy_out !== 1'b1 && n < 50) begin
            @(negedge clock);
            n++;
        end
        d = dd_in;
        dior_n = 1'b1;
        repeat (3) @(negedge clock);
        cs_n = 2'h3;
    endtask
    // Acknowledge and stop levels; selects stay negated meanwhile
    task automatic ctl(input logic ack_n, input logic stop);
        @(negedge clock);
        dmack_n = ack_n;
        diow_n = stop;
        drv = 1'b0;
    endtask
    // Host ready level for data-in bursts
    task automatic hrdy(input logic rdy_n);
        @(negedge clock);
        dior_n = rdy_n;
    endtask
    // One data-out word on the next strobe edge, once the device is ready
    task automatic hstrobe(input logic [15:0] d);
        int n;
        n = 0;
        while (iordy_out !== 1'b0 && n < 50) begin
            @(negedge clock);
            n++;
        end
        dd_h = d;
        drv = 1'b1;
        @(negedge clock);
        dior_n = ~dior_n;
        repeat (2) @(negedge clock);
    endtask
endmodule

/* File: sim/testbench.sv */
`timescale 1ns/10ps

// Bench top: port under test, host model, core-side stimulus
module testbench;
    import psp_pkg::*;
    logic clock = 1'b0;
    logic link_clk = 1'b0;
    logic rst = 1'b1;
    logic dev_sel = 1'b1;
    logic int_pending = 1'b1;
    logic int_disable = 1'b0;
    logic is_dev1 = 1'b0;
    logic reset_proto = 1'b0;
    logic dma_pending = 1'b0;
    logic dev_active = 1'b0;
    logic dma_dir_in = 1'b0;
    logic in_valid = 1'b0;
    logic out_ready = 1'b1;
    logic iordy_oe_n, dmarq_oe_n, dasp_out, reg_rd_req, reg_rd_ctl, in_ready;
    logic [3:0] rq;
    logic [1:0] cs_n;
    logic [2:0] da, reg_wr_addr, reg_rd_addr;
    logic [15:0] dd_in, dd_out, reg_wr_data, out_data, v;
    logic dior_n, diow_n, dmack_n, dd_oe_n, iordy_out, dmarq_out, intrq_out;
    logic intrq_oe_n, dasp_oe_n, reg_wr_valid, reg_wr_ctl, burst_end, out_valid;
    logic [19:0] wq[$];
    logic [15:0] oq[$];
    int miscompares = 0;
    int comparisons = 0;
    int ends = 0;
    int n;
    // Free-running clocks; the link clock has its own phase
    initial forever #20 clock = ~clock;
    initial begin
        #3;
        forever #7.5 link_clk = ~link_clk;
    end
    psp_port uut (.clock, .rst, .link_clk, .cs_n, .da, .dior_n, .diow_n, .dmack_n,
        .dd_in, .dd_out, .dd_oe_n, .iordy_out, .iordy_oe_n, .dmarq_out,
        .dmarq_oe_n, .intrq_out, .intrq_oe_n, .dasp_out, .dasp_oe_n, .dev_sel,
        .int_pending, .int_disable, .is_dev1, .reset_proto, .dev_active,
        .reg_wr_valid, .reg_wr_ctl, .reg_wr_addr, .reg_wr_data, .reg_rd_req,
        .reg_rd_ctl, .reg_rd_addr, .reg_rd_data(16'hA5C3), .dma_pending,
        .dma_dir_in, .burst_end, .in_valid, .in_data(16'h9ABC),
        .in_ready, .out_valid, .out_data, .out_ready);
    psp_host host (.clock, .dd_out, .dd_oe_n, .iordy_out, .cs_n, .da, .dior_n,
        .diow_n, .dmack_n, .dd_in);
    // One-cycle pulses are caught where they have settled
    always @(negedge clock) begin
        if (out_valid === 1'b1) oq.push_back(out_data);
        if (reg_wr_valid === 1'b1) wq.push_back({reg_wr_ctl, reg_wr_addr, reg_wr_data});
        if (burst_end === 1'b1) ends++;
        if (reg_rd_req === 1'b1) rq = {reg_rd_ctl, reg_rd_addr};
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        if (miscompares == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // Data port keeps 16 bits, a control register only its low byte, no select is ignored
    task automatic t_wr;
        host.wr(PSP_CS_CMD, PSP_DATA_ADDR, 16'hBEEF);
        host.wr(PSP_CS_CTL, 3'h6, 16'h1234);
        host.wr(2'h3, 3'h1, 16'h5555);
        repeat (10) @(negedge clock);
        chk("wr_count", wq.size(), 2);
        chk("wr_data", wq[0], {1'b0, 3'h0, 16'hBEEF});
        chk("wr_ctl", wq[1], {1'b1, 3'h6, 16'h0034});
    endtask
    // Reads from both register groups
    task automatic t_rd;
        host.rd(PSP_CS_CTL, 3'h6, v);
        chk("rd_ctl", v, 16'h00C3);
        chk("rd_req", rq, {1'b1, 3'h6});
        host.rd(PSP_CS_CMD, PSP_DATA_ADDR, v);
        chk("rd_data", v, 16'hA5C3);
    endtask
    // Interrupt enable follows the disable bit; presence during reset protocol
    task automatic t_pins;
        repeat (4) @(negedge clock);
        chk("intrq_oe", intrq_oe_n, 1'b0);
        chk("intrq", intrq_out, 1'b1);
        int_disable = 1'b1;
        is_dev1 = 1'b1;
        reset_proto = 1'b1;
        repeat (4) @(negedge clock);
        chk("intrq_off", intrq_oe_n, 1'b1);
        chk("dasp_oe", dasp_oe_n, 1'b0);
        chk("sel_oe", {iordy_oe_n, dmarq_oe_n}, 2'h0);
        reset_proto = 1'b0;
        repeat (4) @(negedge clock);
        chk("dasp_idle", dasp_oe_n, 1'b1);
        dev_active = 1'b1;
        repeat (4) @(negedge clock);
        chk("dasp_act", {dasp_oe_n, dasp_out}, 2'h0);
        dev_active = 1'b0;
    endtask
    // Data-out burst with a pause between words, ended by stop
    task automatic t_dma;
        dma_pending = 1'b1;
        n = 0;
        while (dmarq_out !== 1'b1 && n < 40) begin
            @(negedge clock);
            n++;
        end
        chk("dmarq_up", dmarq_out, 1'b1);
        host.ctl(1'b0, 1'b1);
        dma_pending = 1'b0;
        host.ctl(1'b0, 1'b0);
        out_ready = 1'b0;
        repeat (4) @(negedge clock);
        chk("rdy_pause", iordy_out, 1'b1);
        out_ready = 1'b1;
        host.hstrobe(16'h1357);
        repeat (12) @(negedge clock);
        host.hstrobe(16'h2468);
        repeat (10) @(negedge clock);
        chk("dmarq_hold", dmarq_out, 1'b1);
        chk("out_count", oq.size(), 2);
        chk("out0", oq[0], 16'h1357);
        chk("out1", oq[1], 16'h2468);
        host.ctl(1'b0, 1'b1);
        repeat (10) @(negedge clock);
        chk("burst_end", ends, 1);
        chk("dmarq_dn", dmarq_out, 1'b0);
        host.ctl(1'b1, 1'b1);
    endtask
    // Data-in burst: one word, one strobe toggle, ended by stop
    task automatic t_din;
        dma_dir_in = 1'b1;
        dma_pending = 1'b1;
        repeat (8) @(negedge clock);
        chk("dmarq_in", dmarq_out, 1'b1);
        host.ctl(1'b0, 1'b1);
        dma_pending = 1'b0;
        host.ctl(1'b0, 1'b0);
        host.hrdy(1'b0);
        in_valid = 1'b1;
        @(negedge clock);
        chk("in_busy", in_ready, 1'b0);
        in_valid = 1'b0;
        repeat (12) @(negedge clock);
        chk("din_oe", dd_oe_n, 1'b0);
        chk("din_data", dd_out, 16'h9ABC);
        chk("dstrobe", iordy_out, 1'b0);
        chk("in_ready", in_ready, 1'b1);
        host.ctl(1'b0, 1'b1);
        repeat (10) @(negedge clock);
        chk("din_end", ends, 2);
        host.ctl(1'b1, 1'b1);
        host.hrdy(1'b1);
    endtask
    // Reset, then the scenarios in turn
    initial begin
        repeat (12) @(negedge clock);
        rst = 1'b0;
        repeat (5) @(negedge clock);
        t_wr();
        t_rd();
        t_pins();
        t_dma();
        t_din();
        close_out();
    end
    // Hang guard, well beyond the expected run
    initial begin
        #200000;
        miscompares++;
        close_out();
    end
endmodule
